// [hw/serial_device_end.sv]
// Device end: the memory side of the multi-width serial link pins.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Restart low aborts work, returns to standby.
// - Line 0: single input, or data bit 0.
// - Line 1: single output, or data bit 1.
// - Line 2: write protect, or quad bit 2.
// - Line 3: pause input, or quad bit 3.
// - Dual and quad transfers besides single width.
// - Everything serial over seven pins.
// - Capture rising; output on falling or both.
// - Select high: ignore clock and data, release all outputs.
// - Config bit 1 enables quad, disables protect/pause.
// - Host sends eight-bit instruction first.
module serial_device_end
   import multi_width_serial_pkg::*;
(
   input wire logic clk, // System clock.
   input wire logic resetn, // Asynchronous reset, active low.
   serial_link_if.dev link, // Link pins.
   output logic [7:0] cmd_code, // Last instruction received.
   output logic cmd_start, // Pulse: cmd_code is new.
   output logic [7:0] rx_byte, // Byte received from the host.
   output logic rx_valid, // Pulse: rx_byte is new.
   input wire logic [7:0] tx_byte, // Byte to return, held until taken.
   output logic tx_take, // Pulse: tx_byte was taken.
   output logic quad_mode, // Quad mode enable from config_reg.
   output logic write_protect_n, // Write protect level, high in quad mode.
   output logic paused, // Transfer suspended by the pause input.
   output logic selected // Device selected by the host.
);
   dev_state_t st_r, st_nxt;
   cmd_info_t info_r, info_nxt;
   logic [PIN_N-1:0] s1_r, s2_r, s3_r, f_r;
   logic [7:0] config_reg, cfg_nxt;
   logic [7:0] sh_r, sh_nxt, rxb_nxt, code_nxt, byte_w;
   logic [2:0] slot_r, slot_nxt;
   logic [3:0] drv_r, drv_nxt, oe_r, oe_nxt;
   logic hold_r, hold_nxt, live_r, live_nxt, first_r, first_nxt;
   logic start_nxt, rxv_nxt, take_nxt;

   // A pin level counts once the second and third stages agree.
   wire [PIN_N-1:0] pins = {link.restart_n, link.cs_n, link.sck, link.dq};
   wire [PIN_N-1:0] agree = ~(s2_r ^ s3_r);
   wire [PIN_N-1:0] f_nxt = (agree & s3_r) | (~agree & f_r);

   // Decoded pin events.
   wire restart_lo = ~f_nxt[PIN_RST];
   wire cs_hi = f_nxt[PIN_CS];
   wire sck_lo = ~f_nxt[PIN_SCK];
   wire sck_up = f_nxt[PIN_SCK] & ~f_r[PIN_SCK];
   wire sck_dn = ~f_nxt[PIN_SCK] & f_r[PIN_SCK];
   wire [3:0] lines = f_nxt[3:0];

   // Mode selection from config_reg.
   wire quad_on = config_reg[CFG_QUAD_BIT];
   wire pause_en = ~quad_on;

   // Serial clock edges that the transfer logic acts on.
   wire rise = sck_up & ~hold_nxt;
   wire fall = sck_dn & ~hold_nxt;
   wire last = (slot_r == slot_last(info_r.w));
   wire [2:0] slot_inc = last ? 3'h0 : slot_r + 3'h1;
   wire [7:0] rx_w = shift_in(sh_r, lines, info_r.w, 1'h0);
   wire [7:0] opc_w = shift_in(sh_r, lines, W_ONE, 1'h0);
   wire cmd_info_t dec_w = cmd_decode(opc_w);
   wire refuse = ~dec_w.ok | ((dec_w.w == W_FOUR) & ~quad_on);

   // Pause condition; line 3 only starts or ends it while the serial clock is low; restart, select high or quad mode end it at once.
   always_comb begin
      hold_nxt = hold_r;
      if (restart_lo || cs_hi || !pause_en) begin
         hold_nxt = 1'h0;
      end else if (sck_lo) begin
         hold_nxt = ~lines[3];
      end
   end

   // Transfer state machine.
   always_comb begin
      st_nxt = st_r;
      info_nxt = info_r;
      cfg_nxt = config_reg;
      sh_nxt = sh_r;
      slot_nxt = slot_r;
      drv_nxt = drv_r;
      live_nxt = live_r;
      first_nxt = first_r;
      code_nxt = cmd_code;
      rxb_nxt = rx_byte;
      start_nxt = 1'h0;
      rxv_nxt = 1'h0;
      take_nxt = 1'h0;
      byte_w = (slot_r == 3'h0) ? tx_byte : sh_r;
      if (restart_lo) begin
         st_nxt = D_IDLE;
         cfg_nxt = CFG_RESET;
         live_nxt = 1'h0;
      end else if (cs_hi) begin
         st_nxt = D_IDLE;
         live_nxt = 1'h0;
      end else begin
         case (st_r)
            D_IDLE: begin
               slot_nxt = 3'h0;
               first_nxt = 1'h1;
               st_nxt = D_OPC;
            end
            D_OPC: begin
               if (rise) begin
                  sh_nxt = opc_w;
                  slot_nxt = slot_r + 3'h1;
                  if (slot_r == OPC_LAST) begin
                     slot_nxt = 3'h0;
                     code_nxt = opc_w;
                     start_nxt = 1'h1;
                     info_nxt = dec_w;
                     if (refuse) st_nxt = D_SKIP;
                     else st_nxt = dec_w.rd ? D_DUMMY : D_DIN;
                  end
               end
            end
            D_DIN: begin
               if (rise) begin
                  sh_nxt = rx_w;
                  slot_nxt = slot_inc;
                  if (last) begin
                     rxv_nxt = 1'h1;
                     rxb_nxt = rx_w;
                     first_nxt = 1'h0;
                     if (first_r && cmd_code == OP_WRITE_CFG) cfg_nxt = rx_w;
                  end
               end
            end
            D_DUMMY: begin
               if (rise) begin
                  live_nxt = 1'h0;
                  st_nxt = D_DOUT;
               end
            end
            D_DOUT: begin
               if (fall || (rise && info_r.ddr && live_r)) begin
                  take_nxt = (slot_r == 3'h0);
                  drv_nxt = lines_out(byte_w, info_r.w, 1'h1);
                  sh_nxt = shift_out(byte_w, info_r.w);
                  slot_nxt = slot_inc;
                  live_nxt = 1'h1;
               end
            end
            D_SKIP: st_nxt = D_SKIP;
            default: st_nxt = D_IDLE;
         endcase
      end
   end

   // Drive enables follow the active width and fall away in pause.
   assign oe_nxt = (st_nxt == D_DOUT && live_nxt && !hold_nxt)
                   ? line_mask(info_r.w, 1'h1) : 4'h0;

   // Three-stage synchronisers for every link pin.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_r <= 7'h6F;
         s2_r <= 7'h6F;
         s3_r <= 7'h6F;
         f_r <= 7'h6F;
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
         f_r <= f_nxt;
      end
   end

   // Transfer registers.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= D_IDLE;
         info_r <= '0;
         config_reg <= CFG_RESET;
         {sh_r, slot_r, cmd_code, rx_byte} <= '0;
         {drv_r, oe_r} <= 8'h00;
         {hold_r, live_r, first_r} <= 3'h0;
      end else begin
         st_r <= st_nxt;
         info_r <= info_nxt;
         config_reg <= cfg_nxt;
         {sh_r, slot_r, cmd_code, rx_byte} <= {sh_nxt, slot_nxt, code_nxt, rxb_nxt};
         {drv_r, oe_r} <= {drv_nxt, oe_nxt};
         {hold_r, live_r, first_r} <= {hold_nxt, live_nxt, first_nxt};
      end
   end

   // User-side status and pulses.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         {cmd_start, rx_valid, tx_take} <= 3'h0;
         {write_protect_n, paused, selected} <= 3'h4;
      end else begin
         {cmd_start, rx_valid, tx_take} <= {start_nxt, rxv_nxt, take_nxt};
         write_protect_n <= quad_on | lines[2];
         paused <= hold_nxt;
         selected <= ~cs_hi;
      end
   end

   // Quad mode straight from the configuration register.
   assign quad_mode = quad_on;

   // Device line drivers come straight from registers.
   assign link.dev_o = drv_r;
   assign link.dev_oe = oe_r;
endmodule
`default_nettype wire

// [hw/multi_width_serial_pkg.sv]
// Shared constants, types and decoders for the multi-width serial link.
package multi_width_serial_pkg;
   // System clock and serial clock timing.
   localparam int CLK_NS = 5; // System clock period in ns.
   localparam int SCK_HALF_NS = 40; // Least serial clock half period in ns.
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
   // Instruction length and configuration layout.
   localparam logic [2:0] OPC_LAST = 3'h7; // Last bit slot of the instruction.
   localparam int CFG_QUAD_BIT = 1; // Quad mode enable bit of config_reg.
   localparam logic [7:0] CFG_RESET = 8'h00; // Value of config_reg after restart.
   // Positions of the link pins in the device's synchroniser vector.
   localparam int PIN_SCK = 4;
   localparam int PIN_CS = 5;
   localparam int PIN_RST = 6;
   localparam int PIN_N = 7;
   // Transfer width selectors.
   localparam logic [1:0] W_ONE = 2'h0;
   localparam logic [1:0] W_TWO = 2'h1;
   localparam logic [1:0] W_FOUR = 2'h2;
   // Instruction codes understood by both ends.
   localparam logic [7:0] OP_WRITE_CFG = 8'h01;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
   localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
   localparam logic [7:0] OP_QUAD_DDR_OUT = 8'hED;
   localparam logic [7:0] OP_DUAL_IN = 8'hA2;
   localparam logic [7:0] OP_QUAD_IN = 8'h32;

   typedef struct packed {
      logic ok;
      logic rd;
      logic ddr;
      logic [1:0] w;
   } cmd_info_t;

   typedef enum logic [5:0] {
      D_IDLE = 6'h01, D_OPC = 6'h02, D_DIN = 6'h04,
      D_DUMMY = 6'h08, D_DOUT = 6'h10, D_SKIP = 6'h20
   } dev_state_t;

   typedef enum logic [6:0] {
      H_IDLE = 7'h01, H_OPC = 7'h02, H_DIN = 7'h04, H_DUMMY = 7'h08,
      H_DOUT = 7'h10, H_END = 7'h20, H_GAP = 7'h40
   } host_state_t;

   // Maps an instruction to its direction, rate and width.
   function automatic cmd_info_t cmd_decode(input logic [7:0] op);
      case (op)
         OP_WRITE_CFG: return '{1'h1, 1'h0, 1'h0, W_ONE};
         OP_READ: return '{1'h1, 1'h1, 1'h0, W_ONE};
         OP_DUAL_OUT: return '{1'h1, 1'h1, 1'h0, W_TWO};
         OP_QUAD_OUT: return '{1'h1, 1'h1, 1'h0, W_FOUR};
         OP_QUAD_DDR_OUT: return '{1'h1, 1'h1, 1'h1, W_FOUR};
         OP_DUAL_IN: return '{1'h1, 1'h0, 1'h0, W_TWO};
         OP_QUAD_IN: return '{1'h1, 1'h0, 1'h0, W_FOUR};
         default: return '0;
      endcase
   endfunction

   // Last slot index of a byte at a given width.
   function automatic logic [2:0] slot_last(input logic [1:0] w);
      return (w == W_FOUR) ? 3'h1 : (w == W_TWO) ? 3'h3 : 3'h7;
   endfunction

   // Shifts one chunk of line levels into a byte, most significant first.
   function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] ln,
                                           input logic [1:0] w, input logic hi);
      case (w)
         W_FOUR: return {sh[3:0], ln};
         W_TWO: return {sh[5:0], ln[1:0]};
         default: return {sh[6:0], hi ? ln[1] : ln[0]};
      endcase
   endfunction

   // Drops the chunk already sent from the top of a byte.
   function automatic logic [7:0] shift_out(input logic [7:0] b, input logic [1:0] w);
      return (w == W_FOUR) ? {b[3:0], 4'h0} : (w == W_TWO) ? {b[5:0], 2'h0} : {b[6:0], 1'h0};
   endfunction

   // Places the top chunk of a byte on the lines; hi selects line 1 for single width.
   function automatic logic [3:0] lines_out(input logic [7:0] b, input logic [1:0] w,
                                            input logic hi);
      case (w)
         W_FOUR: return b[7:4];
         W_TWO: return {2'h0, b[7:6]};
         default: return hi ? {2'h0, b[7], 1'h0} : {3'h0, b[7]};
      endcase
   endfunction

   // Lines a sender drives at a given width.
   function automatic logic [3:0] line_mask(input logic [1:0] w, input logic hi);
      return (w == W_FOUR) ? 4'hF : (w == W_TWO) ? 4'h3 : (hi ? 4'h2 : 4'h1);
   endfunction
endpackage

// [hw/serial_link_if.sv]
// Interface joining the host end and the device end of the serial link.
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
   logic sck; // Serial clock from the host.
   logic cs_n; // Chip select from the host, active low.
   logic restart_n; // Hardware restart from the host, active low.
   logic [3:0] host_o; // Host drive levels for data lines 0..3.
   logic [3:0] host_oe; // Host drive enables.
   logic [3:0] dev_o; // Device drive levels.
   logic [3:0] dev_oe; // Device drive enables.
   wire [3:0] dq; // Resolved line levels; undriven lines are pulled high.
   wire [3:0] clash; // Both ends drive the same line.

   // Line resolution: the driving end wins, otherwise the pull-up.
   assign dq = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o) | (~dev_oe & ~host_oe);
   assign clash = dev_oe & host_oe;

   modport dev (input sck, cs_n, restart_n, dq, output dev_o, dev_oe);
   modport host (output sck, cs_n, restart_n, host_o, host_oe, input dq);
endinterface
`default_nettype wire

// [hw/serial_host_end.sv]
// Host end: drives the serial clock, select and commands onto the link.
`timescale 1ns/1ps
`default_nettype none
module serial_host_end
   import multi_width_serial_pkg::*;
#(
   parameter int LEN_W = 8, // Width of the byte count.
   parameter int HALF_CYC = SCK_HALF_CYC // Clocks per serial clock half period.
) (
   input wire logic clk, // System clock.
   input wire logic resetn, // Asynchronous reset, active low.
   serial_link_if.host link, // Link pins.
   input wire logic cmd_valid, // Command request.
   output logic cmd_ready, // Ready to take a command.
   input wire logic [7:0] cmd_code, // Instruction code.
   input wire logic [LEN_W-1:0] cmd_len, // Data bytes to move.
   input wire logic [7:0] wr_byte, // Byte to send, held until taken.
   output logic wr_take, // Pulse: wr_byte was taken.
   output logic [7:0] rd_byte, // Received byte.
   output logic rd_valid, // Pulse: rd_byte is new.
   input wire logic restart_req // Hold the device in restart.
);
   host_state_t st_r, st_nxt;
   cmd_info_t info_r, info_nxt;
   logic [15:0] div_r;
   logic [7:0] sh_r, sh_nxt, rdb_nxt, byte_w;
   logic [2:0] slot_r, slot_nxt;
   logic [LEN_W-1:0] len_r, len_nxt;
   logic [3:0] o_r, o_nxt, oe_r, oe_nxt;
   logic sck_r, sck_nxt, cs_r, cs_nxt, rdy_nxt, take_nxt, rdv_nxt, armed_r, armed_nxt;
   logic rst_r;
   wire tick = (div_r == 16'(HALF_CYC - 1));
   wire rise = tick & ~sck_r;
   wire fall = tick & sck_r;
   wire last = (slot_r == slot_last(info_r.w));
   wire [2:0] slot_inc = last ? 3'h0 : slot_r + 3'h1;
   wire [LEN_W-1:0] len_dec = len_r - LEN_W'(1);
   wire [7:0] rx_w = shift_in(sh_r, link.dq, info_r.w, 1'h1);

   // Next-state logic, one serial clock edge per divider tick.
   always_comb begin
      st_nxt = st_r;
      info_nxt = info_r;
      sh_nxt = sh_r;
      slot_nxt = slot_r;
      len_nxt = len_r;
      o_nxt = o_r;
      oe_nxt = oe_r;
      sck_nxt = sck_r;
      cs_nxt = cs_r;
      rdy_nxt = cmd_ready;
      take_nxt = 1'h0;
      rdv_nxt = 1'h0;
      rdb_nxt = rd_byte;
      armed_nxt = armed_r;
      byte_w = (slot_r == 3'h0) ? wr_byte : sh_r;
      case (st_r)
         H_IDLE: begin
            if (cmd_valid && cmd_ready) begin
               cs_nxt = 1'h0;
               rdy_nxt = 1'h0;
               info_nxt = cmd_decode(cmd_code);
               len_nxt = cmd_len;
               sh_nxt = cmd_code;
               o_nxt = lines_out(cmd_code, W_ONE, 1'h0);
               oe_nxt = line_mask(W_ONE, 1'h0);
               slot_nxt = 3'h0;
               st_nxt = H_OPC;
            end
         end
         H_OPC: begin
            if (rise) begin
               sck_nxt = 1'h1;
               slot_nxt = slot_r + 3'h1;
               if (slot_r == OPC_LAST) begin
                  slot_nxt = 3'h0;
                  st_nxt = info_r.rd ? H_DUMMY : (len_r == '0 ? H_END : H_DIN);
               end
            end else if (fall) begin
               sck_nxt = 1'h0;
               sh_nxt = {sh_r[6:0], 1'h0};
               o_nxt = lines_out({sh_r[6:0], 1'h0}, W_ONE, 1'h0);
            end
         end
         H_DIN: begin
            if (rise) begin
               sck_nxt = 1'h1;
               slot_nxt = slot_inc;
               if (last) begin
                  len_nxt = len_dec;
                  if (len_dec == '0) st_nxt = H_END;
               end
            end else if (fall) begin
               sck_nxt = 1'h0;
               take_nxt = (slot_r == 3'h0);
               o_nxt = lines_out(byte_w, info_r.w, 1'h0);
               oe_nxt = line_mask(info_r.w, 1'h0);
               sh_nxt = shift_out(byte_w, info_r.w);
            end
         end
         H_DUMMY: begin
            if (fall) begin
               sck_nxt = 1'h0;
               oe_nxt = 4'h0;
            end else if (rise) begin
               sck_nxt = 1'h1;
               armed_nxt = 1'h0;
               st_nxt = (len_r == '0) ? H_END : H_DOUT;
            end
         end
         H_DOUT: begin
            if (tick) sck_nxt = ~sck_r;
            if (rise || (fall && info_r.ddr && armed_r)) begin
               armed_nxt = 1'h1;
               sh_nxt = rx_w;
               slot_nxt = slot_inc;
               if (last) begin
                  rdv_nxt = 1'h1;
                  rdb_nxt = rx_w;
                  len_nxt = len_dec;
                  if (len_dec == '0) st_nxt = H_END;
               end
            end
         end
         H_END: begin
            if (fall) begin
               sck_nxt = 1'h0;
            end else if (rise) begin
               cs_nxt = 1'h1;
               oe_nxt = 4'h0;
               st_nxt = H_GAP;
            end
         end
         H_GAP: begin
            if (tick) begin
               rdy_nxt = 1'h1;
               st_nxt = H_IDLE;
            end
         end
         default: st_nxt = H_IDLE;
      endcase
   end

   // Serial clock divider; it restarts when a command is taken, so that select
   // leads the first serial clock rise by a full half period.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) div_r <= 16'h0000;
      else if (tick || (st_r == H_IDLE && cmd_valid && cmd_ready)) div_r <= 16'h0000;
      else div_r <= div_r + 16'h0001;
   end

   // State and pin registers.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= H_IDLE;
         info_r <= '0;
         {sh_r, rd_byte, slot_r, len_r} <= '0;
         {o_r, oe_r} <= 8'h00;
         {sck_r, cs_r, cmd_ready, wr_take, rd_valid, armed_r, rst_r} <= 7'h31;
      end else begin
         st_r <= st_nxt;
         info_r <= info_nxt;
         {sh_r, rd_byte, slot_r, len_r} <= {sh_nxt, rdb_nxt, slot_nxt, len_nxt};
         {o_r, oe_r} <= {o_nxt, oe_nxt};
         {sck_r, cs_r, cmd_ready, wr_take, rd_valid} <= {sck_nxt, cs_nxt, rdy_nxt, take_nxt, rdv_nxt};
         armed_r <= armed_nxt;
         rst_r <= ~restart_req;
      end
   end

   // All link pins come straight from registers.
   assign link.sck = sck_r;
   assign link.cs_n = cs_r;
   assign link.restart_n = rst_r;
   assign link.host_o = o_r;
   assign link.host_oe = oe_r;
endmodule
`default_nettype wire

// [tb/multi_width_serial_asserts.sv]
// Concurrent checks on the wires between the host end and the device end.
`timescale 1ns/1ps
`default_nettype none
module multi_width_serial_asserts (
   input wire logic clk, // System clock.
   input wire logic resetn, // Reset, active low.
   input wire logic sck, // Serial clock.
   input wire logic cs_n, // Select, active low.
   input wire logic restart_n, // Device restart, active low.
   input wire logic [3:0] host_o, // Host line levels.
   input wire logic [3:0] host_oe, // Host line enables.
   input wire logic [3:0] dev_oe, // Device line enables.
   input wire logic [3:0] clash // Double drive flags.
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Deselect and restart need the device synchronisers to settle first.
   sequence desel_hold_s; cs_n [*8]; endsequence
   sequence restart_hold_s; !restart_n [*8]; endsequence
   // Each property but no_clash_a, host_lanes_a and dev_lanes_a ties a link wire to the event that permits it.
   desel_release_a: assert property (desel_hold_s |-> dev_oe == 4'h0)
      else $error("device drives while deselected");
   restart_release_a: assert property (restart_hold_s |-> dev_oe == 4'h0)
      else $error("device drives while held in restart");
   drive_after_select_a: assert property (dev_oe != 4'h0 |-> !$past(cs_n, 8))
      else $error("device drives without a select");
   no_clash_a: assert property (clash == 4'h0)
      else $error("both ends drive one line");
   turnaround_gap_a: assert property ($rose(|dev_oe) |-> $past(host_oe, 2) == 4'h0)
      else $error("device drives too soon after the host");
   host_lanes_a: assert property (host_oe inside {4'h0, 4'h1, 4'h3, 4'hF})
      else $error("host drives an illegal line set");
   dev_lanes_a: assert property (dev_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
      else $error("device drives an illegal line set");
   host_change_low_a: assert property
      ((host_oe != 4'h0 && $changed(host_o & host_oe)) |-> !sck)
      else $error("host data changes while the serial clock is high");
   rise_stable_a: assert property ($rose(sck) |-> $stable(host_o & host_oe) && !cs_n)
      else $error("host data moves at a capture edge");
   select_setup_a: assert property ($fell(cs_n) |-> (!sck) [*6])
      else $error("serial clock rises too soon after select");
   idle_clock_a: assert property (cs_n |-> !sck)
      else $error("serial clock high while deselected");
endmodule
`default_nettype wire

// [tb/multi_io_serial_pin_interface_test.sv]
// Self-checking bench joining the host end and the device end of the link.
`timescale 1ns/1ps
`default_nettype none
module multi_io_serial_pin_interface_test
   import multi_width_serial_pkg::*;
;
   logic clk, resetn, cmd_valid, restart_req, cmd_ready, wr_take, rd_valid;
   logic [7:0] cmd_code, cmd_len, wr_byte, rd_byte, tx_byte, dev_code, rx_byte;
   logic cmd_start, rx_valid, tx_take, quad_mode, write_protect_n, paused, selected;
   logic [7:0] rd_seen, rx_seen, rx_cnt;
   logic [7:0] start_cnt, take_cnt, wtake_cnt;
   int bad_count, total_checks;
   logic [7:0] rd_ops [4] = '{OP_READ, OP_DUAL_OUT, OP_QUAD_OUT, OP_QUAD_DDR_OUT};
   logic [7:0] rd_data [4] = '{8'h5A, 8'hC3, 8'h96, 8'h3C};
   logic [7:0] wr_ops [2] = '{OP_DUAL_IN, OP_QUAD_IN};
   logic [7:0] wr_data [2] = '{8'hA5, 8'h69};

   serial_link_if link ();
   serial_host_end #(.LEN_W(8), .HALF_CYC(8)) u_serial_host_end (
      .clk(clk), .resetn(resetn), .link(link.host), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_len(cmd_len), .wr_byte(wr_byte),
      .wr_take(wr_take), .rd_byte(rd_byte), .rd_valid(rd_valid), .restart_req(restart_req));
   serial_device_end u_serial_device_end (
      .clk(clk), .resetn(resetn), .link(link.dev), .cmd_code(dev_code),
      .cmd_start(cmd_start), .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_byte(tx_byte),
      .tx_take(tx_take), .quad_mode(quad_mode), .write_protect_n(write_protect_n),
      .paused(paused), .selected(selected));
   multi_width_serial_asserts u_multi_width_serial_asserts (
      .clk(clk), .resetn(resetn), .sck(link.sck), .cs_n(link.cs_n),
      .restart_n(link.restart_n), .host_o(link.host_o), .host_oe(link.host_oe),
      .dev_oe(link.dev_oe), .clash(link.clash));

   // The clock runs at 200 MHz.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Keeps the last byte each end delivered, and counts device bytes.
   always @(posedge clk) begin
      if (rd_valid === 1'b1) rd_seen <= rd_byte;
      if (cmd_start === 1'b1) start_cnt <= start_cnt + 8'h01;
      if (tx_take === 1'b1) take_cnt <= take_cnt + 8'h01;
      if (wr_take === 1'b1) wtake_cnt <= wtake_cnt + 8'h01;
      if (rx_valid === 1'b1) begin
         rx_seen <= rx_byte;
         rx_cnt <= rx_cnt + 8'h01;
      end
   end

   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check1(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Issues one single-byte command and waits, bounded, for the host to go idle.
   task automatic run_cmd(input logic [7:0] code, input logic [7:0] wb);
      int i;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_code <= code;
      wr_byte <= wb;
      @(posedge clk);
      cmd_valid <= 1'b0;
      repeat (3) @(posedge clk);
      for (i = 0; i < 2000; i++) begin
         @(posedge clk);
         if (cmd_ready === 1'b1) break;
      end
      if (i == 2000) begin
         bad_count++;
         $display("FAIL cmd_ready expected 1 seen %b", cmd_ready);
         complete_run();
      end
      repeat (4) @(posedge clk);
   endtask

   // Main sequence: configure, read and write at every width, restart, refusals.
   initial begin
      logic [7:0] cnt;
      resetn = 1'b0;
      cmd_valid = 1'b0;
      restart_req = 1'b0;
      cmd_code = 8'h00;
      cmd_len = 8'h01;
      wr_byte = 8'h00;
      tx_byte = 8'h00;
      rd_seen = 8'h00;
      rx_seen = 8'h00;
      rx_cnt = 8'h00;
      {start_cnt, take_cnt, wtake_cnt} = 24'h00_0000;
      bad_count = 0;
      total_checks = 0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      repeat (6) @(posedge clk);
      check1("cmd_ready", 1'b1, cmd_ready);
      check1("quad_mode", 1'b0, quad_mode);
      check1("selected", 1'b0, selected);
      check1("paused", 1'b0, paused);
      run_cmd(OP_WRITE_CFG, 8'h02);
      check8("config byte", 8'h02, rx_seen);
      check8("instruction", OP_WRITE_CFG, dev_code);
      check1("quad_mode", 1'b1, quad_mode);
      check1("write_protect_n", 1'b1, write_protect_n);
      for (int k = 0; k < 4; k++) begin
         tx_byte <= rd_data[k];
         run_cmd(rd_ops[k], 8'h00);
         check8("read byte", rd_data[k], rd_seen);
      end
      for (int k = 0; k < 2; k++) begin
         run_cmd(wr_ops[k], wr_data[k]);
         check8("written byte", wr_data[k], rx_seen);
      end
      restart_req <= 1'b1;
      repeat (12) @(posedge clk);
      check1("quad_mode", 1'b0, quad_mode);
      check1("selected", 1'b0, selected);
      restart_req <= 1'b0;
      repeat (12) @(posedge clk);
      cnt = rx_cnt;
      run_cmd(OP_QUAD_IN, 8'h77);
      check8("refused write count", cnt, rx_cnt);
      run_cmd(OP_QUAD_OUT, 8'h00);
      check8("refused read byte", 8'hFF, rd_seen);
      tx_byte <= 8'h5A;
      run_cmd(OP_READ, 8'h00);
      check8("read after restart", 8'h5A, rd_seen);
      // Ten commands, four of them with a write byte; every served read takes two.
      check8("cmd_start count", 8'h0A, start_cnt);
      check8("wr_take count", 8'h04, wtake_cnt);
      check8("tx_take count", 8'h0A, take_cnt);
      complete_run();
   end
endmodule
`default_nettype wire
